// File: shared/tlb_defines.svh
// Sizes, field positions and reset values of the translation buffer
`ifndef TLB_DEFINES_SVH
`define TLB_DEFINES_SVH

`define TLB_ENTRIES     64
`define TLB_SETS        32
`define TLB_SET_BITS    5
`define TLB_IDX_BITS    6
`define TLB_TID_BITS    8
`define TLB_PAGE_BITS   12
`define TLB_VPN_BITS    20
// Word 0 (tag word) field positions
`define TLB_W0_VALID    11
`define TLB_W0_WR_OK    10
`define TLB_W0_RD_OK    9
`define TLB_W0_EX_OK    8
// Word 1: bits 31:12 physical page, 11:0 user control field
`define TLB_W1_USER_MSB 11
`define TLB_ENT_RESET   64'h0000_0000_0000_0000
`define TLB_LRU_RESET   32'h0000_0000

`endif

// File: shared/tlb_pkg.sv
// Types shared by the address translator and its surroundings
package tlb_pkg;

  typedef enum logic [2:0] {
    ACC_LOAD,
    ACC_STORE,
    ACC_BRANCH,
    ACC_PF_START,
    ACC_PF_NEXT
  } acc_e;

  typedef struct packed {
    logic        valid;
    acc_e        kind;
    logic [31:0] vaddr;
    logic        supv;
    logic        real_acc;
  } req_s;

  typedef struct packed {
    logic        valid;
    logic        write;
    logic [5:0]  idx;
    logic        hi;
    logic [31:0] wdata;
  } sw_s;

  typedef struct packed {
    logic        valid;
    acc_e        kind;
    logic [31:0] paddr;
  } xout_s;

  typedef struct packed {
    logic        valid;
    logic        miss;
    logic        prot;
    logic [31:0] vaddr;
    logic [5:0]  repl_idx;
  } trap_s;

  typedef struct packed {
    logic [63:0][63:0] ent;
    logic [31:0]       lru;
    req_s              ex;
    logic [19:0]       pf_ppn;
    logic              pf_ok;
    xout_s             xout;
    trap_s             trap;
    logic [31:0]       sw_rdata;
  } state_s;

endpackage

// File: core/tlb_address_translator.sv
// Address translator with 64-entry two-way look-aside buffer
`timescale 1ns/1ps
`default_nettype none
`include "tlb_defines.svh"

module tlb_address_translator (
  input  wire logic          mclk,
  input  wire logic          rst_n,
  input  wire tlb_pkg::req_s dec_req,
  input  wire logic [7:0]    cur_tid,
  input  wire logic          data_xlate_en,
  input  wire logic          instr_xlate_en,
  input  wire tlb_pkg::sw_s  sw_req,
  output tlb_pkg::xout_s     wb_out,
  output tlb_pkg::trap_s     trap_out,
  output logic [31:0]        sw_rdata
);
  import tlb_pkg::*;

  state_s st_r;
  state_s st_nxt;

  // Tag word matches address and current task
  function automatic logic tag_hit(input logic [31:0] w0,
                                   input logic [31:0] va,
                                   input logic [7:0]  tid);
    tag_hit = w0[`TLB_W0_VALID] &&
              (w0[31:`TLB_PAGE_BITS] == va[31:`TLB_PAGE_BITS]) &&
              (w0[`TLB_TID_BITS-1:0] == tid);
  endfunction

  // Protection check; supervisor passes everything
  function automatic logic perm_ok(input logic [31:0] w0,
                                   input acc_e        k,
                                   input logic        supv);
    logic ok;
    ok = 1'b0;
    case (k)
      ACC_LOAD:  ok = w0[`TLB_W0_RD_OK];
      ACC_STORE: ok = w0[`TLB_W0_WR_OK];
      default:   ok = w0[`TLB_W0_EX_OK];
    endcase
    perm_ok = supv | ok;
  endfunction

  logic [`TLB_SET_BITS-1:0] set;
  logic [`TLB_IDX_BITS-1:0] idx0;
  logic [`TLB_IDX_BITS-1:0] idx1;
  logic                     hit0;
  logic                     hit1;
  logic                     is_instr;
  logic                     xlate;
  logic                     pf_pass;
  logic [63:0]              hent;

  always_comb begin
    st_nxt = st_r;
    st_nxt.xout.valid = 1'b0;
    st_nxt.trap.valid = 1'b0;
    // Address evaluated in decode is held for the execute stage
    st_nxt.ex = dec_req;

    set  = st_r.ex.vaddr[`TLB_PAGE_BITS+`TLB_SET_BITS-1:`TLB_PAGE_BITS];
    idx0 = {set, 1'b0};
    idx1 = {set, 1'b1};
    hit0 = tag_hit(st_r.ent[idx0][31:0], st_r.ex.vaddr, cur_tid);
    hit1 = tag_hit(st_r.ent[idx1][31:0], st_r.ex.vaddr, cur_tid);
    hent = hit0 ? st_r.ent[idx0] : st_r.ent[idx1];

    is_instr = (st_r.ex.kind == ACC_BRANCH) ||
               (st_r.ex.kind == ACC_PF_START) ||
               (st_r.ex.kind == ACC_PF_NEXT);
    // Sequential prefetch within a known page reuses the last page frame
    pf_pass = (st_r.ex.kind == ACC_PF_NEXT) && st_r.pf_ok &&
              (st_r.ex.vaddr[`TLB_PAGE_BITS-1:2] != 10'h000);
    xlate = (is_instr ? instr_xlate_en : data_xlate_en) &&
            !(st_r.ex.supv && st_r.ex.real_acc && !is_instr);

    if (st_r.ex.valid) begin
      st_nxt.xout.kind = st_r.ex.kind;
      if (!xlate) begin
        st_nxt.xout.valid = 1'b1;
        st_nxt.xout.paddr = st_r.ex.vaddr;
      end else if (pf_pass) begin
        st_nxt.xout.valid = 1'b1;
        st_nxt.xout.paddr = {st_r.pf_ppn,
                             st_r.ex.vaddr[`TLB_PAGE_BITS-1:0]};
      end else if (!(hit0 | hit1)) begin
        // Miss: nothing issued, victim taken from line LRU
        st_nxt.trap.valid    = 1'b1;
        st_nxt.trap.miss     = 1'b1;
        st_nxt.trap.prot     = 1'b0;
        st_nxt.trap.vaddr    = st_r.ex.vaddr;
        st_nxt.trap.repl_idx = {set, st_r.lru[set]};
        if (is_instr) begin
          st_nxt.pf_ok = 1'b0;
        end
      end else begin
        // Hit makes the other way least recently used
        st_nxt.lru[set] = hit0;
        if (!perm_ok(hent[31:0], st_r.ex.kind, st_r.ex.supv)) begin
          st_nxt.trap.valid    = 1'b1;
          st_nxt.trap.miss     = 1'b0;
          st_nxt.trap.prot     = 1'b1;
          st_nxt.trap.vaddr    = st_r.ex.vaddr;
          st_nxt.trap.repl_idx = {set, st_r.lru[set]};
        end else begin
          // Result registered for write-back, next request already entering
          st_nxt.xout.valid = 1'b1;
          st_nxt.xout.paddr = {hent[63:32+`TLB_PAGE_BITS],
                               st_r.ex.vaddr[`TLB_PAGE_BITS-1:0]};
          if (is_instr) begin
            st_nxt.pf_ppn = hent[63:32+`TLB_PAGE_BITS];
            st_nxt.pf_ok  = 1'b1;
          end
        end
      end
    end

    // Software access to entry words; only path that alters an entry
    if (sw_req.valid) begin
      if (sw_req.write) begin
        if (sw_req.hi) begin
          st_nxt.ent[sw_req.idx][63:32] = sw_req.wdata;
        end else begin
          st_nxt.ent[sw_req.idx][31:0] = sw_req.wdata;
        end
        st_nxt.pf_ok = 1'b0;
      end else begin
        st_nxt.sw_rdata = sw_req.hi ? st_r.ent[sw_req.idx][63:32]
                                    : st_r.ent[sw_req.idx][31:0];
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      for (int i = 0; i < `TLB_ENTRIES; i++) begin
        st_r.ent[i] <= `TLB_ENT_RESET;
      end
      st_r.lru      <= `TLB_LRU_RESET;
      st_r.ex       <= '0;
      st_r.pf_ppn   <= '0;
      st_r.pf_ok    <= 1'b0;
      st_r.xout     <= '0;
      st_r.trap     <= '0;
      st_r.sw_rdata <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign wb_out   = st_r.xout;
  assign trap_out = st_r.trap;
  assign sw_rdata = st_r.sw_rdata;

endmodule
`default_nettype wire

// File: tb/decode_model.sv
// Decode stage model that feeds requests to the translator
`timescale 1ns/1ps
`default_nettype none
module decode_model (
  input  wire logic          mclk,
  input  wire logic          rst_n,
  input  wire tlb_pkg::req_s cmd,
  output tlb_pkg::req_s      dec_req
);
  import tlb_pkg::*;
  // Addresses formed in decode reach execute one edge later
  always_ff @(posedge mclk) dec_req <= rst_n ? cmd : '0;
endmodule
`default_nettype wire

// File: tb/tlb_address_translator_assertions.sv
// Port checker for the address translator
`timescale 1ns/1ps
`default_nettype none
module tlb_checks import tlb_pkg::*; (
  input wire logic  mclk,
  input wire logic  rst_n,
  input wire req_s  dec_req,
  input wire logic  data_xlate_en,
  input wire xout_s wb_out,
  input wire trap_s trap_out
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_n);
  a_one_answer: assert property (dec_req.valid |=> ##1
    wb_out.valid ^ trap_out.valid) else $error("no answer");
  a_no_stray: assert property (wb_out.valid || trap_out.valid
    |-> $past(dec_req.valid, 2)) else $error("stray pulse");
  a_kind_kept: assert property (wb_out.valid
    |-> wb_out.kind == $past(dec_req.kind, 2)) else $error("kind");
  a_page_off: assert property (wb_out.valid |->
    wb_out.paddr[11:0] == $past(dec_req.vaddr[11:0], 2)) else $error("off");
  a_trap_addr: assert property (trap_out.valid
    |-> trap_out.vaddr == $past(dec_req.vaddr, 2)) else $error("trap va");
  a_trap_cause: assert property (trap_out.valid
    |-> trap_out.miss || trap_out.prot) else $error("no cause");
  a_no_both: assert property (!(wb_out.valid && trap_out.valid))
    else $error("both pulses");
  a_real_pass: assert property (dec_req.valid
    && dec_req.kind inside {ACC_LOAD, ACC_STORE} && (!data_xlate_en
    || dec_req.supv && dec_req.real_acc) |=> ##1 wb_out.valid
    && wb_out.paddr == $past(dec_req.vaddr, 2)) else $error("real");
endmodule
bind tlb_address_translator tlb_checks u_chk (.mclk, .rst_n, .dec_req,
  .data_xlate_en, .wb_out, .trap_out);
`default_nettype wire

// File: tb/test_tlb_address_translator.sv
// Self-checking bench for the address translator
`timescale 1ns/1ps
`default_nettype none
module test_tlb_address_translator;
  import tlb_pkg::*;
  typedef struct packed {
    acc_e k; logic [31:0] va; logic s; logic r; logic w; logic [31:0] pa;
  } row_s;
  logic        mclk = 1'b0;
  logic        rst_n = 1'b0;
  logic        dxe = 1'b1;
  logic        ixe = 1'b1;
  logic [7:0]  tid = 8'h05;
  req_s        cmd = '0;
  req_s        dec_req;
  sw_s         sw_req = '0;
  xout_s       wb_out;
  trap_s       trap_out;
  logic [31:0] sw_rdata;
  int          err_count = 0;
  int          samples_checked = 0;
  int          cyc = 0;
  // Entry at set 1 way 0 maps page 1 to page ab123, no execute right
  row_s rows [7] = '{
    '{ACC_LOAD, 32'h0000_1234, 0, 0, 1, 32'hab12_3234},
    '{ACC_STORE, 32'h0000_1ffc, 0, 0, 1, 32'hab12_3ffc},
    '{ACC_BRANCH, 32'h0000_1000, 0, 0, 0, 32'h0},
    '{ACC_LOAD, 32'h0000_2000, 0, 0, 0, 32'h0},
    '{ACC_LOAD, 32'h1234_5678, 1, 1, 1, 32'h1234_5678},
    '{ACC_PF_START, 32'h0000_1010, 1, 0, 1, 32'hab12_3010},
    '{ACC_PF_NEXT, 32'h0000_1020, 1, 0, 1, 32'hab12_3020}};
  decode_model i_src (.mclk, .rst_n, .cmd, .dec_req);
  tlb_address_translator i_dut (.mclk, .rst_n, .dec_req, .cur_tid(tid),
    .data_xlate_en(dxe), .instr_xlate_en(ixe), .sw_req, .wb_out,
    .trap_out, .sw_rdata);
  always #5 mclk = ~mclk;
  task automatic conclude();
    $display("checked %0d mismatches %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 1000) begin
      err_count++;
      conclude();
    end
  end
  task automatic chk(string n, logic [31:0] e, logic [31:0] g);
    samples_checked++;
    if (g !== e) begin
      err_count++;
      $display("BAD %s exp %h got %h", n, e, g);
    end
  endtask
  task automatic tick(int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask
  task automatic sw(logic w, logic [5:0] i, logic h, logic [31:0] d);
    sw_req = '{1'b1, w, i, h, d};
    tick(1);
    sw_req.valid = 1'b0;
    tick(1);
  endtask
  task automatic go(logic [31:0] va);
    cmd = '{1'b1, ACC_LOAD, va, 1'b0, 1'b0};
    tick(1);
    cmd.valid = 1'b0;
    tick(2);
  endtask
  initial begin
    tick(20);
    rst_n = 1'b1;
    tick(1);
    sw(1, 6'd2, 0, 32'h0000_1e05);
    sw(1, 6'd2, 1, 32'hab12_35a5);
    for (int i = 0; i < 10; i++) begin
      if (i >= 3) begin
        chk("wb", rows[i-3].w, wb_out.valid);
        chk("trap", !rows[i-3].w, trap_out.valid);
        if (rows[i-3].w) chk("pa", rows[i-3].pa, wb_out.paddr);
      end
      if (i < 7)
        cmd = '{1'b1, rows[i].k, rows[i].va, rows[i].s, rows[i].r};
      else
        cmd = '0;
      tick(1);
    end
    $display("table done");
    go(32'h0000_2004);
    chk("victim", 6'd4, trap_out.repl_idx);
    tid = 8'h06;
    go(32'h0000_1234);
    chk("tid", 1, trap_out.valid & trap_out.miss);
    tid = 8'h05;
    dxe = 1'b0;
    go(32'h0000_2004);
    chk("off", 32'h0000_2004, wb_out.paddr);
    dxe = 1'b1;
    sw(0, 6'd2, 1, '0);
    chk("w1", 32'hab12_35a5, sw_rdata);
    sw(0, 6'd2, 0, '0);
    chk("w0", 32'h0000_1e05, sw_rdata);
    $display("hand done");
    rst_n = 1'b0;
    tick(1);
    rst_n = 1'b1;
    tick(1);
    sw(0, 6'd2, 0, '0);
    chk("rst", 0, sw_rdata);
    $display("reset done");
    conclude();
  end
endmodule
`default_nettype wire
